// File: rtl/pcmcs_pkg.sv
// constants for the voice port clock, frame sync and frame format block
package pcmcs_pkg;
  // -----------------------------------------------------------------
  // register offsets (byte addresses)
  // -----------------------------------------------------------------
  localparam logic [3:0] PCMCS_OFF_PORT = 4'h0;
  localparam logic [3:0] PCMCS_OFF_DIV = 4'h4;
  localparam logic [3:0] PCMCS_OFF_AUX = 4'h8;
  // -----------------------------------------------------------------
  // reset values
  // -----------------------------------------------------------------
  localparam logic [31:0] PCMCS_PORT_RST = 32'h0080_0000;
  localparam logic [31:0] PCMCS_DIV_RST = 32'h0808_0177;
  localparam logic [2:0] PCMCS_GAIN_RST = 3'h0;
  // -----------------------------------------------------------------
  // port configuration fields
  // -----------------------------------------------------------------
  localparam int PCMCS_B_SLAVE = 1;
  localparam int PCMCS_B_SHORT = 2;
  localparam int PCMCS_B_SEXT = 4;
  localparam int PCMCS_B_LSB = 5;
  localparam int PCMCS_B_TRI = 6;
  localparam int PCMCS_B_TRI_RISE = 7;
  localparam int PCMCS_B_SUPPR = 8;
  localparam int PCMCS_B_ALT_LINE = 9;
  localparam int PCMCS_B_MUTE = 10;
  localparam int PCMCS_B_HIGH_RATE = 11;
  localparam int PCMCS_B_LONG_LEN = 12;
  localparam int PCMCS_F_RATE_LO = 21;
  localparam int PCMCS_F_FMT_LO = 27;
  localparam logic [1:0] PCMCS_RATE_128 = 2'h1;
  localparam logic [1:0] PCMCS_RATE_256 = 2'h0;
  localparam logic [1:0] PCMCS_RATE_512 = 2'h2;
  localparam logic [1:0] PCMCS_FMT_13 = 2'h0;
  localparam logic [1:0] PCMCS_FMT_16 = 2'h1;
  localparam logic [1:0] PCMCS_FMT_8 = 2'h2;
  localparam logic [1:0] PCMCS_FMT_8S = 2'h3;
  // divider configuration fields
  localparam int PCMCS_F_LIMIT_LO = 0;
  localparam int PCMCS_F_CRATE_LO = 16;
  localparam int PCMCS_F_SLIM_LO = 24;
  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam longint PCMCS_CLK_HZ = 20_000_000;
  localparam longint PCMCS_HR_MHZ = 48;
  localparam longint PCMCS_SYS_MHZ = PCMCS_CLK_HZ / 1_000_000;
  localparam longint PCMCS_FRAME_HZ = 8_000;
  localparam longint PCMCS_ACC_MOD_LO = 65536;
  // phase increment per clk for a given bit clock (two toggles per period)
  localparam longint PCMCS_INC_128 = (2 * 128_000 * PCMCS_ACC_MOD_LO + PCMCS_CLK_HZ / 2)
                                     / PCMCS_CLK_HZ;
  localparam longint PCMCS_INC_256 = (2 * 256_000 * PCMCS_ACC_MOD_LO + PCMCS_CLK_HZ / 2)
                                     / PCMCS_CLK_HZ;
  localparam longint PCMCS_INC_512 = (2 * 512_000 * PCMCS_ACC_MOD_LO + PCMCS_CLK_HZ / 2)
                                     / PCMCS_CLK_HZ;
  localparam logic [11:0] PCMCS_FLEN_128 = 12'(128_000 / PCMCS_FRAME_HZ);
  localparam logic [11:0] PCMCS_FLEN_256 = 12'(256_000 / PCMCS_FRAME_HZ);
  localparam logic [11:0] PCMCS_FLEN_512 = 12'(512_000 / PCMCS_FRAME_HZ);
  localparam logic [11:0] PCMCS_SYNC_SHORT_LEN = 12'h008;
  localparam logic [11:0] PCMCS_SYNC_LONG_LEN = 12'h010;
  localparam logic [11:0] PCMCS_FLEN_ZERO_LIMIT = 12'h800;
endpackage : pcmcs_pkg

// File: rtl/pcmcs_core.sv
// voice port bit clock / frame sync generator with frame format and serial data path
//
// How it works
// - slow source gives 128/256/512k clock, 8k sync
// - bit 11 picks slow or fast source
// - bit 12 makes fast-source long sync 8 or 16
// - fast source clock equals rate/limit times 24M
// - fast source sync equals clock over 8*sync-limit
// - divider word: limit, rate, sync-limit fields
// - bit 1 selects master or slave clocking
// - bit 2: long rising or short falling start
// - 13-bit samples padded with gain, 8-bit padded low, or sign-extended
// - bit 5 selects MSB or LSB first
// - bit 6 floats output after active slot
// - bit 7 picks falling or rising float edge
// - bit 8 holds master sync low, clock runs
// - bit 10 forces serial output to zero
// - bits 22:21 select slow-source clock rate
// - bits 28:27 select sample and slot layout
// - active-slot field stored, otherwise ignored
// - port word resets to 0x00800000
//
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/1ps
module pcmcs_core
  import pcmcs_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [3:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  input wire logic bclk_in,
  output logic bclk_out,
  output logic bclk_oe,
  input wire logic fsync_in,
  output logic fsync_out,
  output logic fsync_oe,
  input wire logic sdin,
  output logic sdout,
  output logic sdout_oe,
  input wire logic [15:0] tx_sample,
  output logic tx_taken,
  output logic [15:0] rx_sample,
  output logic rx_valid
);
  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] port_cfg;
    logic [31:0] div_cfg;
    logic [2:0] gain;
    logic [31:0] rd_data;
    logic [17:0] acc;
    logic bclk;
    logic fsync;
    logic bclk_s1;
    logic bclk_s2;
    logic bclk_s3;
    logic fs_s1;
    logic fs_s2;
    logic fs_smp;
    logic fs_prev;
    logic din_s1;
    logic din_s2;
    logic [11:0] bit_cnt;
    logic [15:0] tx_word;
    logic [15:0] rx_word;
    logic [15:0] rx_sample;
    logic rx_valid;
    logic tx_taken;
    logic sdout;
    logic sdout_oe;
  } pcmcs_state_t;

  pcmcs_state_t st_reg;
  pcmcs_state_t st_next;

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  // position in the slot word of the bit sent or taken at slot bit cnt
  function automatic logic [3:0] pcmcs_bit_pos(input logic [11:0] cnt,
                                               input logic [4:0] slot_len,
                                               input logic lsb_first);
    logic [4:0] pos;
    pos = lsb_first ? cnt[4:0] : 5'(slot_len - 5'h01 - cnt[4:0]);
    return pos[3:0];
  endfunction : pcmcs_bit_pos

  // internal samples are 16-bit left aligned; narrow formats use the top bits
  function automatic logic [15:0] pcmcs_fmt_tx(input logic [15:0] smp,
                                              input logic [1:0] fmt,
                                              input logic sext,
                                              input logic [2:0] gain);
    logic [15:0] w;
    w = smp;
    case (fmt)
      PCMCS_FMT_13: w = sext ? {{3{smp[15]}}, smp[15:3]} : {smp[15:3], gain};
      PCMCS_FMT_8: w = sext ? {{8{smp[15]}}, smp[15:8]} : {smp[15:8], 8'h00};
      PCMCS_FMT_8S: w = {8'h00, smp[15:8]};
      default: w = smp;
    endcase
    return w;
  endfunction : pcmcs_fmt_tx

  // -----------------------------------------------------------------
  // decoded configuration
  // -----------------------------------------------------------------
  logic slave;
  logic short_sync;
  logic high_rate;
  logic [1:0] rate_sel;
  logic [1:0] fmt;
  logic [12:0] dds_count_limit;
  logic [7:0] dds_count_rate;
  logic [7:0] sync_limit;
  logic [4:0] slot_len;
  logic [11:0] frame_len;
  logic [11:0] sync_len;
  logic [17:0] dds_inc;
  logic [17:0] dds_mod;

  always_comb begin
    slave = st_reg.port_cfg[PCMCS_B_SLAVE];
    short_sync = st_reg.port_cfg[PCMCS_B_SHORT];
    high_rate = st_reg.port_cfg[PCMCS_B_HIGH_RATE];
    rate_sel = st_reg.port_cfg[PCMCS_F_RATE_LO +: 2];
    fmt = st_reg.port_cfg[PCMCS_F_FMT_LO +: 2];
    dds_count_limit = st_reg.div_cfg[PCMCS_F_LIMIT_LO +: 13];
    dds_count_rate = st_reg.div_cfg[PCMCS_F_CRATE_LO +: 8];
    sync_limit = st_reg.div_cfg[PCMCS_F_SLIM_LO +: 8];
    slot_len = (fmt == PCMCS_FMT_8S) ? 5'h08 : 5'h10;
    sync_len = (high_rate && st_reg.port_cfg[PCMCS_B_LONG_LEN]) ?
               PCMCS_SYNC_LONG_LEN : PCMCS_SYNC_SHORT_LEN;
    if (high_rate) begin
      // fast-source phase step scaled from the 48 MHz domain onto clk
      dds_inc = 18'(dds_count_rate * PCMCS_HR_MHZ);
      dds_mod = 18'(dds_count_limit * PCMCS_SYS_MHZ);
      frame_len = (sync_limit == 8'h00) ? PCMCS_FLEN_ZERO_LIMIT :
                  {1'b0, sync_limit, 3'b000};
    end else begin
      dds_mod = 18'(PCMCS_ACC_MOD_LO);
      case (rate_sel)
        PCMCS_RATE_128: begin
          dds_inc = 18'(PCMCS_INC_128);
          frame_len = PCMCS_FLEN_128;
        end
        PCMCS_RATE_512: begin
          dds_inc = 18'(PCMCS_INC_512);
          frame_len = PCMCS_FLEN_512;
        end
        default: begin
          dds_inc = 18'(PCMCS_INC_256);
          frame_len = PCMCS_FLEN_256;
        end
      endcase
    end
  end

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  logic [18:0] dds_sum;
  logic toggle;
  logic rise;
  logic fall;
  logic start;
  logic [11:0] nb;
  logic [3:0] pos;
  logic [15:0] rxw;
  logic [15:0] txw;

  always_comb begin
    st_next = st_reg;
    dds_sum = '0;
    toggle = 1'b0;
    start = 1'b0;
    nb = st_reg.bit_cnt;
    pos = '0;
    rxw = st_reg.rx_word;
    txw = st_reg.tx_word;
    st_next.rx_valid = 1'b0;
    st_next.tx_taken = 1'b0;
    // link inputs come from another domain: two flops before any use
    st_next.bclk_s1 = bclk_in;
    st_next.bclk_s2 = st_reg.bclk_s1;
    st_next.bclk_s3 = st_reg.bclk_s2;
    st_next.fs_s1 = fsync_in;
    st_next.fs_s2 = st_reg.fs_s1;
    st_next.din_s1 = sdin;
    st_next.din_s2 = st_reg.din_s1;

    // register port
    if (wr_en) begin
      case (addr)
        PCMCS_OFF_PORT: st_next.port_cfg = wr_data;
        PCMCS_OFF_DIV: st_next.div_cfg = wr_data;
        PCMCS_OFF_AUX: st_next.gain = wr_data[2:0];
        default: ;
      endcase
    end
    st_next.rd_data = 32'h0000_0000;
    if (rd_en) begin
      case (addr)
        PCMCS_OFF_PORT: st_next.rd_data = st_reg.port_cfg;
        PCMCS_OFF_DIV: st_next.rd_data = st_reg.div_cfg;
        PCMCS_OFF_AUX: st_next.rd_data = {4'h0, st_reg.bit_cnt, 13'h0000, st_reg.gain};
        default: st_next.rd_data = 32'h0000_0000;
      endcase
    end

    // bit clock: own accumulator as master, sampled pin as slave
    if (slave) begin
      st_next.acc = '0;
      st_next.bclk = 1'b0;
      rise = st_reg.bclk_s2 & ~st_reg.bclk_s3;
      fall = ~st_reg.bclk_s2 & st_reg.bclk_s3;
    end else begin
      dds_sum = {1'b0, st_reg.acc} + {1'b0, dds_inc};
      if (dds_mod != 18'h00000 && dds_sum >= {1'b0, dds_mod}) begin
        st_next.acc = 18'(dds_sum - {1'b0, dds_mod});
        toggle = 1'b1;
      end else begin
        st_next.acc = dds_sum[17:0];
      end
      if (toggle) begin
        st_next.bclk = ~st_reg.bclk;
      end
      rise = toggle & ~st_reg.bclk;
      fall = toggle & st_reg.bclk;
    end

    // falling edge: slave samples sync, both roles take receive data
    if (fall) begin
      st_next.fs_smp = st_reg.fs_s2;
      st_next.fs_prev = st_reg.fs_smp;
      if (st_reg.bit_cnt < 12'(slot_len)) begin
        pos = pcmcs_bit_pos(st_reg.bit_cnt, slot_len,
                            st_reg.port_cfg[PCMCS_B_LSB]);
        rxw[pos] = st_reg.din_s2;
        st_next.rx_word = rxw;
        if (st_reg.bit_cnt == 12'(slot_len - 5'h01)) begin
          st_next.rx_sample = rxw;
          st_next.rx_valid = 1'b1;
          // float right after the falling edge of the last slot bit
          if (st_reg.port_cfg[PCMCS_B_TRI] && !st_reg.port_cfg[PCMCS_B_TRI_RISE] &&
              frame_len > 12'(slot_len)) begin
            st_next.sdout_oe = 1'b0;
          end
        end
      end
    end

    // rising edge: advance the bit position, drive sync and data
    if (rise) begin
      if (slave) begin
        if (short_sync) begin
          start = ~st_reg.fs_smp & st_reg.fs_prev;
        end else begin
          start = st_reg.fs_smp & ~st_reg.fs_prev;
        end
        if (start) begin
          nb = 12'h000;
          st_next.fs_prev = st_reg.fs_smp;
        end else if (st_reg.bit_cnt != 12'hFFF) begin
          nb = st_reg.bit_cnt + 12'h001;
        end
      end else begin
        nb = (st_reg.bit_cnt + 12'h001 >= frame_len) ? 12'h000 : st_reg.bit_cnt + 12'h001;
        start = (nb == 12'h000);
        if (short_sync) begin
          st_next.fsync = (nb == frame_len - 12'h001);
        end else begin
          st_next.fsync = (nb == 12'h000) | (st_reg.fsync & (nb < sync_len));
        end
      end
      st_next.bit_cnt = nb;
      if (start) begin
        txw = pcmcs_fmt_tx(tx_sample, fmt, st_reg.port_cfg[PCMCS_B_SEXT], st_reg.gain);
        st_next.tx_word = txw;
        st_next.tx_taken = 1'b1;
        st_next.sdout_oe = 1'b1;
      end
      if (nb < 12'(slot_len)) begin
        pos = pcmcs_bit_pos(nb, slot_len, st_reg.port_cfg[PCMCS_B_LSB]);
        st_next.sdout = txw[pos];
      end else begin
        st_next.sdout = 1'b0;
        if (nb == 12'(slot_len) && st_reg.port_cfg[PCMCS_B_TRI] &&
            st_reg.port_cfg[PCMCS_B_TRI_RISE] && frame_len > 12'(slot_len)) begin
          st_next.sdout_oe = 1'b0;
        end
      end
    end

    if (slave || st_reg.port_cfg[PCMCS_B_SUPPR]) begin
      st_next.fsync = 1'b0;
    end
    if (st_next.port_cfg[PCMCS_B_SLAVE]) begin
      st_next.bclk = 1'b0;
    end
    if (!st_reg.port_cfg[PCMCS_B_TRI]) begin
      st_next.sdout_oe = 1'b1;
    end
    if (st_reg.port_cfg[PCMCS_B_MUTE]) begin
      st_next.sdout = 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // state register
  // -----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '0;
      st_reg.port_cfg <= PCMCS_PORT_RST;
      st_reg.div_cfg <= PCMCS_DIV_RST;
      st_reg.gain <= PCMCS_GAIN_RST;
      st_reg.sdout_oe <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rd_data = st_reg.rd_data;
  assign bclk_out = st_reg.bclk;
  assign bclk_oe = ~st_reg.port_cfg[PCMCS_B_SLAVE];
  assign fsync_out = st_reg.fsync;
  assign fsync_oe = ~st_reg.port_cfg[PCMCS_B_SLAVE];
  assign sdout = st_reg.sdout;
  assign sdout_oe = st_reg.sdout_oe;
  assign tx_taken = st_reg.tx_taken;
  assign rx_sample = st_reg.rx_sample;
  assign rx_valid = st_reg.rx_valid;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  AST_SLAVE_QUIET: assert property (@(posedge clk) disable iff (srst)
    st_reg.port_cfg[PCMCS_B_SLAVE] |-> !bclk_oe && !fsync_oe && !bclk_out)
    else $error("slave drives link clock or sync");
  AST_MASTER_DRIVES: assert property (@(posedge clk) disable iff (srst)
    !st_reg.port_cfg[PCMCS_B_SLAVE] |-> bclk_oe && fsync_oe)
    else $error("master not driving link clock or sync");
  AST_MUTE_ZERO: assert property (@(posedge clk) disable iff (srst)
    st_reg.port_cfg[PCMCS_B_MUTE] |=> !sdout)
    else $error("muted output not zero");
  AST_SYNC_SUPPR: assert property (@(posedge clk) disable iff (srst)
    st_reg.port_cfg[PCMCS_B_SUPPR] && $stable(st_reg.port_cfg) |=> !fsync_out)
    else $error("suppressed sync active");
  AST_DRIVE_CONT: assert property (@(posedge clk) disable iff (srst)
    !st_reg.port_cfg[PCMCS_B_TRI] |=> sdout_oe)
    else $error("output floated while continuous drive selected");
  AST_PORT_RESET: assert property (@(posedge clk)
    srst |=> st_reg.port_cfg == PCMCS_PORT_RST)
    else $error("port word reset value wrong");
  AST_DIV_WRITE: assert property (@(posedge clk) disable iff (srst)
    wr_en && addr == PCMCS_OFF_DIV |=> st_reg.div_cfg == $past(wr_data))
    else $error("divider word write lost");
  AST_LONG_START: assert property (@(posedge clk) disable iff (srst)
    $rose(fsync_out) && !st_reg.port_cfg[PCMCS_B_SHORT] && $stable(st_reg.port_cfg)
    |-> st_reg.bit_cnt == 12'h000)
    else $error("long sync rise not at frame start");
  AST_TRI_FALL: assert property (@(posedge clk) disable iff (srst)
    fall && st_reg.port_cfg[PCMCS_B_TRI] && !st_reg.port_cfg[PCMCS_B_TRI_RISE] &&
    st_reg.bit_cnt == 12'(slot_len - 5'h01) && frame_len > 12'(slot_len) |=> !sdout_oe)
    else $error("output not floated after last slot bit");
  AST_DDS_RANGE: assert property (@(posedge clk) disable iff (srst)
    !slave && dds_mod != 18'h00000 && dds_inc < dds_mod && st_reg.acc < dds_mod
    |=> st_reg.acc < $past(dds_mod))
    else $error("phase accumulator left its range");
endmodule : pcmcs_core

// File: tb/pcmcs_codec_model.sv
// codec model standing on the far side of the voice port
`timescale 1ns/1ps
module pcmcs_codec_model (
  input wire logic slave_run,
  input wire logic line_clk,
  input wire logic line_sync,
  input wire logic line_short,
  input wire logic sd_from_dev,
  input wire logic sd_oe,
  input wire logic [15:0] send_word,
  output logic m_clk,
  output logic m_sync,
  output logic m_sd,
  output logic [15:0] cap_last,
  output int frame_bits,
  output int starts,
  output logic oe_mid,
  output logic oe_late
);
  logic prev_sync;
  logic start_now;
  logic [15:0] cap;
  int bidx;
  int mcnt;
  initial begin
    {m_clk, m_sync, m_sd, oe_mid, oe_late, prev_sync} = 6'h00;
    cap = 16'h0000;
    cap_last = 16'h0000;
    frame_bits = 0;
    starts = 0;
    bidx = 99;
    mcnt = 0;
  end
  // ---------------------------------------------------------------
  // link clock and sync made here in the slave role, still otherwise
  // ---------------------------------------------------------------
  always #200 m_clk = slave_run ? ~m_clk : 1'h0;
  always @(posedge m_clk) begin
    mcnt <= (mcnt == 31) ? 0 : mcnt + 1;
    m_sync <= (mcnt >= 30) || (mcnt < 6);
  end
  // ---------------------------------------------------------------
  // frame tracking, capture and serial data towards the device
  // ---------------------------------------------------------------
  assign start_now = line_short ? (prev_sync && !line_sync) : (!prev_sync && line_sync);
  always @(negedge line_clk) begin
    prev_sync <= line_sync;
    if (start_now) begin
      starts <= starts + 1;
      frame_bits <= bidx + 1;
      cap_last <= cap;
      bidx <= slave_run ? -1 : 0;
    end else begin
      bidx <= bidx + 1;
    end
    // a slave device opens its slot one bit after it samples the sync
    if ((start_now && !slave_run) || (!start_now && bidx >= -1 && bidx < 15))
      cap <= {cap[14:0], sd_from_dev};
    if (!start_now && bidx == 4) oe_mid <= sd_oe;
    if (!start_now && bidx == 19) oe_late <= sd_oe;
  end
  // data moves just after the rise so it is settled at the sampling fall
  always @(posedge line_clk) begin
    #1;
    if (start_now && !slave_run) m_sd <= send_word[15];
    else if (bidx >= -1 && bidx < 15) m_sd <= send_word[14 - bidx];
    else m_sd <= ~m_sd;
  end
endmodule : pcmcs_codec_model

// File: tb/pcmcs_core_tb.sv
// self-checking bench for the voice port clock, sync and frame block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
  checks++; \
  if ((g) !== (e)) begin \
    err_total++; \
    $display("FAIL %s expected %0h seen %0h", nm, e, g); \
  end \
end
module pcmcs_core_tb;
  typedef struct {
    logic [31:0] port;
    logic [31:0] div;
    logic [15:0] cap;
    logic [15:0] mask;
    int bits;
  } pcmcs_row_t;
  localparam logic [31:0] DIV = 32'h0808_0177;
  pcmcs_row_t rows [10] = '{
    '{32'h0080_0000, DIV, 16'hA5C5, 16'hFFFF, 32},
    '{32'h00A0_0000, DIV, 16'hA5C5, 16'hFFFF, 16},
    '{32'h08C0_0000, DIV, 16'hA5C3, 16'hFFFF, 64},
    '{32'h0080_0010, DIV, 16'hF4B8, 16'hFFFF, 32},
    '{32'h1080_0000, DIV, 16'hA500, 16'hFFFF, 32},
    '{32'h1080_0010, DIV, 16'hFFA5, 16'hFFFF, 32},
    '{32'h1880_0000, DIV, 16'hA500, 16'hFF00, 32},
    '{32'h0880_0020, DIV, 16'hC3A5, 16'hFFFF, 32},
    '{32'h0080_0800, 32'h0408_0177, 16'hA5C5, 16'hFFFF, 32},
    '{32'h0080_0004, DIV, 16'hA5C5, 16'hFFFF, 32}};
  logic [31:0] tri_cfg [3] = '{32'h0880_0000, 32'h0880_0040, 32'h0880_00C0};
  logic clk = 1'h0;
  logic srst = 1'h1;
  logic [3:0] addr = 4'h0;
  logic [31:0] wr_data = 32'h0;
  logic wr_en = 1'h0;
  logic rd_en = 1'h0;
  logic [15:0] tx_sample = 16'hA5C3;
  logic slave_run = 1'h0;
  logic [31:0] cfg_now = 32'h0080_0000;
  logic [31:0] rd_data;
  logic bclk_out, bclk_oe, fsync_out, fsync_oe, sdout, sdout_oe, tx_taken, rx_valid;
  logic [15:0] rx_sample, cap_last;
  logic m_clk, m_sync, m_sd, oe_mid, oe_late, bclk_w, fsync_w;
  int frame_bits, starts;
  int err_total = 0;
  int checks = 0;
  int tx_cnt = 0;
  int rx_cnt = 0;
  always #25 clk = ~clk;
  always @(posedge clk) begin
    if (tx_taken === 1'h1) tx_cnt <= tx_cnt + 1;
    if (rx_valid === 1'h1) rx_cnt <= rx_cnt + 1;
  end
  assign bclk_w = bclk_oe ? bclk_out : m_clk;
  assign fsync_w = fsync_oe ? fsync_out : m_sync;
  pcmcs_core u_pcmcs_core (.clk(clk), .srst(srst), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .bclk_in(bclk_w), .bclk_out(bclk_out),
    .bclk_oe(bclk_oe), .fsync_in(fsync_w), .fsync_out(fsync_out), .fsync_oe(fsync_oe),
    .sdin(m_sd), .sdout(sdout), .sdout_oe(sdout_oe), .tx_sample(tx_sample),
    .tx_taken(tx_taken), .rx_sample(rx_sample), .rx_valid(rx_valid));
  pcmcs_codec_model u_pcmcs_codec_model (.slave_run(slave_run), .line_clk(bclk_w),
    .line_sync(fsync_w), .line_short(cfg_now[2]), .sd_from_dev(sdout), .sd_oe(sdout_oe),
    .send_word(16'h3C96), .m_clk(m_clk), .m_sync(m_sync), .m_sd(m_sd), .cap_last(cap_last),
    .frame_bits(frame_bits), .starts(starts), .oe_mid(oe_mid), .oe_late(oe_late));
  // ---------------------------------------------------------------
  // register port and waiting helpers
  // ---------------------------------------------------------------
  task automatic complete_run();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'h1;
    if (a == 4'h0) cfg_now <= d;
    @(posedge clk);
    wr_en <= 1'h0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    addr <= a;
    rd_en <= 1'h1;
    @(posedge clk);
    rd_en <= 1'h0;
    #1;
    `CHK("read data", e, rd_data & m)
    @(posedge clk);
  endtask : rd
  task automatic wait_starts(input int n);
    int s0;
    s0 = starts;
    for (int i = 0; i < 20000 && starts < s0 + n; i++) @(posedge clk);
    if (starts < s0 + n) begin
      err_total++;
      $display("FAIL frame start wait ran out");
      complete_run();
    end
  endtask : wait_starts
  // counts bit clock rises while the long sync stands high
  task automatic sync_len(input int e);
    int n;
    logic pb;
    n = 0;
    pb = 1'h1;
    for (int i = 0; i < 20000 && fsync_out !== 1'h0; i++) @(posedge clk);
    for (int i = 0; i < 20000; i++) begin
      @(posedge clk);
      #1;
      if (fsync_out && bclk_out && !pb) n++;
      if (n > 0 && !fsync_out) break;
      pb = bclk_out;
    end
    `CHK("sync length", e, n)
  endtask : sync_len
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    int n;
    int hi;
    int t0;
    int r0;
    logic pb;
    repeat (10) @(posedge clk);
    srst <= 1'h0;
    @(posedge clk);
    rd(4'h0, 32'h0080_0000, 32'hFFFF_FFFF);
    rd(4'h4, 32'h0808_0177, 32'hFFFF_FFFF);
    rd(4'hC, 32'h0, 32'hFFFF_FFFF);
    wr(4'h0, 32'h0780_0000);
    wr(4'hC, 32'hFFFF_FFFF);
    rd(4'h0, 32'h0780_0000, 32'hFFFF_FFFF);
    wr(4'h8, 32'h5);
    rd(4'h8, 32'h5, 32'h7);
    foreach (rows[i]) begin
      wr(4'h4, rows[i].div);
      rd(4'h4, rows[i].div, 32'hFFFF_FFFF);
      wr(4'h0, rows[i].port);
      wait_starts(rows[i].port[2] ? 3 : 2);
      `CHK("slot word", rows[i].cap, cap_last & rows[i].mask)
      `CHK("frame bits", rows[i].bits, frame_bits)
    end
    foreach (tri_cfg[i]) begin
      wr(4'h0, tri_cfg[i]);
      wait_starts(2);
      `CHK("drive in slot", 1'h1, oe_mid)
      `CHK("drive after slot", !tri_cfg[i][6], oe_late)
    end
    wr(4'h0, 32'h0880_0400);
    wait_starts(2);
    `CHK("muted slot", 16'h0000, cap_last)
    `CHK("master rx", 16'h3C96, rx_sample)
    wr(4'h0, 32'h0080_0800);
    wait_starts(1);
    sync_len(8);
    wr(4'h0, 32'h0080_1800);
    wait_starts(1);
    sync_len(16);
    wr(4'h0, 32'h0880_0100);
    n = 0;
    hi = 0;
    pb = 1'h1;
    repeat (3000) begin
      @(posedge clk);
      #1;
      if (fsync_out !== 1'h0) hi++;
      if (bclk_out && !pb) n++;
      pb = bclk_out;
    end
    `CHK("sync held", 0, hi)
    `CHK("clock runs", 1'h1, n > 30)
    wr(4'h0, 32'h0880_0022);
    slave_run <= 1'h1;
    t0 = tx_cnt;
    r0 = rx_cnt;
    wait_starts(3);
    `CHK("tx takes", 1'h1, (tx_cnt - t0) >= 2 && (tx_cnt - t0) <= 4)
    `CHK("rx pulses", 1'h1, (rx_cnt - r0) >= 2 && (rx_cnt - r0) <= 4)
    `CHK("clock drive", 1'h0, bclk_oe)
    `CHK("sync drive", 1'h0, fsync_oe)
    `CHK("slave slot", 16'hC3A5, cap_last)
    `CHK("slave rx", 16'h693C, rx_sample)
    slave_run <= 1'h0;
    cfg_now <= 32'h0080_0000;
    srst <= 1'h1;
    repeat (2) @(posedge clk);
    srst <= 1'h0;
    @(posedge clk);
    rd(4'h0, 32'h0080_0000, 32'hFFFF_FFFF);
    rd(4'h8, 32'h0, 32'hFFFF_FFFF);
    `CHK("reset clock drive", 1'h1, bclk_oe)
    `CHK("reset sync drive", 1'h1, fsync_oe)
    complete_run();
  end
endmodule : pcmcs_core_tb
